// File: common/psl_pkg.sv
// Constants, field layouts and carrier types of the strap option latch
package psl_pkg;

  // Register port geometry
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  // Register addresses
  localparam logic [ADDR_W-1:0] REG_CTRL_ADDR = 5'h00;
  localparam logic [ADDR_W-1:0] REG_ADV_ADDR  = 5'h04;
  localparam logic [ADDR_W-1:0] REG_STAT_ADDR = 5'h1F;

  // Control register field positions
  localparam int CTRL_SPEED_BIT = 13;
  localparam int CTRL_AN_BIT    = 12;
  localparam int CTRL_ISO_BIT   = 10;
  localparam int CTRL_DUP_BIT   = 8;

  // Advertisement register field positions and values
  localparam int ADV_CAP_LSB = 5;
  localparam int ADV_CAP_W   = 4;
  localparam int ADV_SEL_W   = 5;
  localparam logic [ADV_SEL_W-1:0] ADV_SELECTOR = 5'h01;
  localparam logic [ADV_CAP_W-1:0] ADV_CAP_ALL  = 4'hF;
  localparam logic [ADV_CAP_W-1:0] ADV_CAP_10   = 4'h3;
  localparam logic [ADV_CAP_W-1:0] ADV_CAP_RST  = 4'hF;

  // Status register field positions
  localparam int STAT_FIBER_BIT = 0;
  localparam int STAT_FEF_BIT   = 1;
  localparam int STAT_DONE_BIT  = 2;

  // Cycles after reset release before the strap levels are taken
  localparam int SETTLE_CYC = 3;
  localparam int CNT_W      = 2;
  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYC - 1);

  // Two-way strap pins, one bit each
  typedef struct packed {
    logic isolate;
    logic speed;
    logic duplex;
    logic autoneg_strap;
  } psl_pins_s;

  // Internal pull levels: isolate and fiber select down, the rest up
  localparam psl_pins_s PIN_PULL = 4'h7;
  localparam logic FIBER_PULL = 1'b0;

  // Configuration produced from the straps
  typedef struct packed {
    logic isolate;
    logic speed_100;
    logic full_duplex;
    logic autoneg_en;
    logic far_fault_en;
    logic fiber_select;
  } psl_cfg_s;

  // Values before capture: the pull defaults in copper mode
  localparam psl_cfg_s CFG_RST = 6'h14;

  typedef enum {SEQ_SETTLE, SEQ_LATCH, SEQ_RUN} psl_seq_e;

endpackage

// File: core/psl_pin.sv
// One strap pin: synchroniser on the input, registered drive afterwards
`timescale 1ns/10ps
module psl_pin
  import psl_pkg::*;
#(
  parameter logic PULL = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic pad_i,
  input  wire logic func_i,
  input  wire logic drive_en,
  output logic      pad_o,
  output logic      pad_oe,
  output logic      level_o
);

  logic meta_q;
  logic level_q;

  // Two-flop synchroniser, resting at the pull level during reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q  <= PULL;
      level_q <= PULL;
    end else begin
      meta_q  <= pad_i;
      level_q <= meta_q;
    end
  end

  // Pin released while straps are sampled, driven once running
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pad_oe <= 1'b0;
      pad_o  <= 1'b0;
    end else begin
      pad_oe <= drive_en;
      pad_o  <= func_i;
    end
  end

  assign level_o = level_q;

  chk_pin_released: assert property (@(posedge clk) disable iff (!rst_b) !drive_en |=> !pad_oe)
    else $error("strap pin driven before capture finished");

endmodule

// File: core/psl_capture_seq.sv
// Capture sequencer: settle after reset release, latch once, then run
`timescale 1ns/10ps
module psl_capture_seq
  import psl_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_b,
  output logic      latch_o,
  output logic      run_o
);

  psl_seq_e         state_q;
  psl_seq_e         state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  // Next state: wait for synchronisers, one latch cycle, then run forever
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      SEQ_SETTLE: begin
        if (cnt_q == SETTLE_LAST) begin
          state_d = SEQ_LATCH;
        end else begin
          cnt_d = cnt_q + CNT_W'(1);
        end
      end
      SEQ_LATCH: state_d = SEQ_RUN;
      SEQ_RUN:   state_d = SEQ_RUN;
      default:   state_d = SEQ_SETTLE;
    endcase
  end

  // State and settle counter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= SEQ_SETTLE;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  assign latch_o = (state_q == SEQ_LATCH);
  assign run_o   = (state_q == SEQ_RUN);

  chk_latch_then_run: assert property (@(posedge clk) disable iff (!rst_b) latch_o |=> run_o && !latch_o)
    else $error("latch pulse not followed by run");

endmodule

// File: core/psl_top.sv
// Strap option latch: samples strap pins after reset and loads configuration
`timescale 1ns/10ps
module psl_top
  import psl_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire psl_pins_s         strap_pad_i,
  output psl_pins_s              strap_pad_o,
  output psl_pins_s              strap_pad_oe,
  input  wire psl_pins_s         strap_func_i,
  input  wire logic              fiber_select_i,
  output psl_cfg_s               cfg_o,
  output logic [ADV_CAP_W-1:0]   adv_cap_o,
  output logic                   strap_done
);

  // Synchronised pin levels and sequencer outputs
  psl_pins_s pin_lvl;
  logic      fiber_lvl;
  logic      latch_p;
  logic      run;

  // Configuration and advertisement state
  psl_cfg_s              cfg_q;
  psl_cfg_s              cfg_d;
  logic [ADV_CAP_W-1:0]  adv_cap_q;
  logic [ADV_CAP_W-1:0]  adv_cap_d;
  logic [DATA_W-1:0]     rdata_q;
  logic [DATA_W-1:0]     rdata_d;

  // Capture sequencing after reset release
  psl_capture_seq u_seq (
    .clk     (clk),
    .rst_b   (rst_b),
    .latch_o (latch_p),
    .run_o   (run)
  );

  // One synchroniser and pad driver per two-way strap pin
  for (genvar i = 0; i < $bits(psl_pins_s); i++) begin : g_pin
    psl_pin #(.PULL(PIN_PULL[i])) u_pin (
      .clk      (clk),
      .rst_b    (rst_b),
      .pad_i    (strap_pad_i[i]),
      .func_i   (strap_func_i[i]),
      .drive_en (run),
      .pad_o    (strap_pad_o[i]),
      .pad_oe   (strap_pad_oe[i]),
      .level_o  (pin_lvl[i])
    );
  end

  // Fiber select is an input only; its drive side stays unused
  psl_pin #(.PULL(FIBER_PULL)) u_fiber (
    .clk      (clk),
    .rst_b    (rst_b),
    .pad_i    (fiber_select_i),
    .func_i   (1'b0),
    .drive_en (1'b0),
    .pad_o    (),
    .pad_oe   (),
    .level_o  (fiber_lvl)
  );

  // Strap decode into configuration values
  wire       cap_fiber    = fiber_lvl;
  wire       cap_isolate  = pin_lvl.isolate;
  wire       cap_speed    = cap_fiber ? 1'b1 : pin_lvl.speed;
  wire       cap_fef      = cap_fiber ? pin_lvl.speed : 1'b0;
  wire       cap_full_dup = ~pin_lvl.duplex;
  wire       cap_autoneg  = pin_lvl.autoneg_strap & ~cap_fiber;
  wire [ADV_CAP_W-1:0] cap_adv = cap_speed ? ADV_CAP_ALL : ADV_CAP_10;

  // Register port decode
  wire wr_ctrl = reg_wr && run && (reg_addr == REG_CTRL_ADDR);
  wire wr_adv  = reg_wr && run && (reg_addr == REG_ADV_ADDR);
  wire rd_ctrl = reg_rd && (reg_addr == REG_CTRL_ADDR);
  wire rd_adv  = reg_rd && (reg_addr == REG_ADV_ADDR);
  wire rd_stat = reg_rd && (reg_addr == REG_STAT_ADDR);

  // Register images
  wire [DATA_W-1:0] ctrl_img = (DATA_W'(cfg_q.speed_100)   << CTRL_SPEED_BIT)
                             | (DATA_W'(cfg_q.autoneg_en)  << CTRL_AN_BIT)
                             | (DATA_W'(cfg_q.isolate)     << CTRL_ISO_BIT)
                             | (DATA_W'(cfg_q.full_duplex) << CTRL_DUP_BIT);
  wire [DATA_W-1:0] adv_img  = (DATA_W'(adv_cap_q) << ADV_CAP_LSB) | DATA_W'(ADV_SELECTOR);
  wire [DATA_W-1:0] stat_img = (DATA_W'(cfg_q.fiber_select) << STAT_FIBER_BIT)
                             | (DATA_W'(cfg_q.far_fault_en) << STAT_FEF_BIT)
                             | (DATA_W'(run)                << STAT_DONE_BIT);

  // Next configuration: one-time capture, then software writes
  always_comb begin
    cfg_d     = cfg_q;
    adv_cap_d = adv_cap_q;
    if (latch_p) begin
      cfg_d.isolate      = cap_isolate;
      cfg_d.speed_100    = cap_speed;
      cfg_d.full_duplex  = cap_full_dup;
      cfg_d.autoneg_en   = cap_autoneg;
      cfg_d.far_fault_en = cap_fef;
      cfg_d.fiber_select = cap_fiber;
      adv_cap_d          = cap_adv;
    end else begin
      if (wr_ctrl) begin
        cfg_d.isolate     = reg_wdata[CTRL_ISO_BIT];
        cfg_d.speed_100   = reg_wdata[CTRL_SPEED_BIT];
        cfg_d.full_duplex = reg_wdata[CTRL_DUP_BIT];
        cfg_d.autoneg_en  = reg_wdata[CTRL_AN_BIT] & ~cfg_q.fiber_select;
      end
      if (wr_adv) begin
        adv_cap_d = reg_wdata[ADV_CAP_LSB +: ADV_CAP_W];
      end
    end
  end

  // Read data valid in the cycle after the strobe only
  always_comb begin
    rdata_d = '0;
    if (rd_ctrl) begin
      rdata_d = ctrl_img;
    end else if (rd_adv) begin
      rdata_d = adv_img;
    end else if (rd_stat) begin
      rdata_d = stat_img;
    end
  end

  // Configuration, advertisement and read data registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q     <= CFG_RST;
      adv_cap_q <= ADV_CAP_RST;
      rdata_q   <= '0;
    end else begin
      cfg_q     <= cfg_d;
      adv_cap_q <= adv_cap_d;
      rdata_q   <= rdata_d;
    end
  end

  assign reg_rdata  = rdata_q;
  assign cfg_o      = cfg_q;
  assign adv_cap_o  = adv_cap_q;
  assign strap_done = run;

  // Checks on capture and pin behaviour
  sequence s_latched;
    latch_p ##1 run;
  endsequence

  // Settle window after release: quiet cycles, then the one latch pulse
  sequence s_settle;
    !latch_p [*3] ##1 latch_p;
  endsequence

  // Loaded value equals the synchronised level seen at the latch pulse
  property p_loads(logic src, logic dst);
    @(posedge clk) disable iff (!rst_b) latch_p |=> (dst == $past(src));
  endproperty

  // Cycles since reset release, saturating; only the checks read it
  logic [2:0] rel_cnt_q;

  // Release counter for the latch slot check
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rel_cnt_q <= '0;
    end else if (rel_cnt_q != 3'h7) begin
      rel_cnt_q <= rel_cnt_q + 3'h1;
    end
  end

  // Isolate: off until capture, then loaded and shown in the control image
  chk_iso_load: assert property (p_loads(pin_lvl.isolate, cfg_q.isolate))
    else $error("isolate strap not loaded");

  chk_iso_default: assert property (@(posedge clk) disable iff (!rst_b)
    !run && !latch_p |-> !cfg_q.isolate)
    else $error("isolate on before capture");

  chk_iso_ctrl_bit: assert property (@(posedge clk) disable iff (!rst_b)
    rd_ctrl |=> reg_rdata[CTRL_ISO_BIT] == $past(cfg_q.isolate))
    else $error("isolate state not seen in control bit");

  // Speed: control bit and advertised capability follow the strap in copper
  chk_speed_load: assert property (@(posedge clk) disable iff (!rst_b)
    (latch_p && !fiber_lvl) |=> cfg_q.speed_100 == $past(pin_lvl.speed)
      && adv_cap_q == ($past(pin_lvl.speed) ? ADV_CAP_ALL : ADV_CAP_10))
    else $error("speed strap not loaded into control and advertisement");

  chk_speed_ctrl_bit: assert property (@(posedge clk) disable iff (!rst_b)
    rd_ctrl |=> reg_rdata[CTRL_SPEED_BIT] == $past(cfg_q.speed_100))
    else $error("speed state not seen in control bit");

  chk_adv_image: assert property (@(posedge clk) disable iff (!rst_b)
    rd_adv |=> reg_rdata[ADV_CAP_LSB +: ADV_CAP_W] == $past(adv_cap_q))
    else $error("advertisement capability misread");

  // Shared pin in fiber mode: speed fixed, pin feeds far-end fault
  chk_fiber_share: assert property (@(posedge clk) disable iff (!rst_b)
    (latch_p && fiber_lvl) |=> cfg_q.speed_100 && cfg_q.far_fault_en == $past(pin_lvl.speed))
    else $error("shared strap misused in fiber mode");

  chk_adv_fiber: assert property (@(posedge clk) disable iff (!rst_b)
    (latch_p && fiber_lvl) |=> adv_cap_q == ADV_CAP_ALL)
    else $error("fiber mode did not advertise full capability");

  // Far-end fault: off in copper, held once captured, shown in status
  chk_fef_copper: assert property (@(posedge clk) disable iff (!rst_b)
    (latch_p && !fiber_lvl) |=> !cfg_q.far_fault_en)
    else $error("far-end fault enabled in copper mode");

  chk_fault_hold: assert property (@(posedge clk) disable iff (!rst_b)
    run |=> $stable(cfg_q.far_fault_en))
    else $error("far-end fault setting changed after capture");

  chk_fault_stat_bit: assert property (@(posedge clk) disable iff (!rst_b)
    rd_stat |=> reg_rdata[STAT_FEF_BIT] == $past(cfg_q.far_fault_en))
    else $error("far-end fault setting misread in status");

  // Duplex: inverted strap level, shown in the control image
  chk_duplex_load: assert property (p_loads(~pin_lvl.duplex, cfg_q.full_duplex))
    else $error("duplex strap not loaded");

  chk_dup_ctrl_bit: assert property (@(posedge clk) disable iff (!rst_b)
    rd_ctrl |=> reg_rdata[CTRL_DUP_BIT] == $past(cfg_q.full_duplex))
    else $error("duplex state not seen in control bit");

  // Auto-negotiation: strap in copper, forced off in fiber
  chk_autoneg_load: assert property (@(posedge clk) disable iff (!rst_b)
    (latch_p && !fiber_lvl) |=> cfg_q.autoneg_en == $past(pin_lvl.autoneg_strap))
    else $error("auto-negotiation strap not loaded");

  chk_an_ctrl_bit: assert property (@(posedge clk) disable iff (!rst_b)
    rd_ctrl |=> reg_rdata[CTRL_AN_BIT] == $past(cfg_q.autoneg_en))
    else $error("auto-negotiation state not seen in control bit");

  chk_fiber_an_off: assert property (@(posedge clk) disable iff (!rst_b)
    run && cfg_q.fiber_select |-> !cfg_q.autoneg_en)
    else $error("auto-negotiation on in fiber mode");

  // Fiber select: captured once, held, shown in status
  chk_fiber_mode: assert property (p_loads(fiber_lvl, cfg_q.fiber_select))
    else $error("fiber select not loaded");

  chk_fiber_hold: assert property (@(posedge clk) disable iff (!rst_b)
    run |=> $stable(cfg_q.fiber_select))
    else $error("fiber select changed after capture");

  chk_fiber_stat_bit: assert property (@(posedge clk) disable iff (!rst_b)
    rd_stat |=> reg_rdata[STAT_FIBER_BIT] == $past(cfg_q.fiber_select))
    else $error("fiber select misread in status");

  // Pins: released while sampling, driven with the functional value after
  chk_pins_drive: assert property (@(posedge clk) disable iff (!rst_b)
    s_latched |=> strap_pad_oe == '1)
    else $error("strap pins not driven after capture");

  chk_pins_float: assert property (@(posedge clk) disable iff (!rst_b)
    !run |-> strap_pad_oe == '0)
    else $error("strap pins driven during capture");

  chk_pad_follow: assert property (@(posedge clk) disable iff (!rst_b)
    run |=> strap_pad_o == $past(strap_func_i))
    else $error("strap pins not showing the functional value");

  // One capture per reset, at a fixed slot after release
  chk_capture_once: assert property (@(posedge clk) disable iff (!rst_b)
    run && !wr_ctrl |=> cfg_q.isolate == $past(cfg_q.isolate)
      && cfg_q.fiber_select == $past(cfg_q.fiber_select))
    else $error("captured strap value changed without a write");

  chk_write_gated: assert property (@(posedge clk) disable iff (!rst_b)
    !run && !latch_p |=> $stable(cfg_q) && $stable(adv_cap_q))
    else $error("configuration changed before capture");

  chk_latch_slot: assert property (@(posedge clk) disable iff (!rst_b)
    latch_p |-> rel_cnt_q == 3'(SETTLE_CYC))
    else $error("latch pulse outside its slot after release");

  chk_settle_time: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(rst_b) |-> s_settle)
    else $error("capture not taken after settle time");

endmodule

// File: bench/psl_board_model.sv
// Board side of the strap pins: resistors and attached receive inputs
`timescale 1ns/10ps
module psl_board_model
  import psl_pkg::*;
(
  input  wire psl_pins_s pad_o,
  input  wire psl_pins_s pad_oe,
  input  wire psl_pins_s res_fit,
  input  wire psl_pins_s res_lvl,
  output psl_pins_s      pad_lvl
);
  // Wire level: device drive, else board resistor, else internal pull
  // Resistors outweigh the attached receive inputs during reset
  assign pad_lvl = (pad_oe & pad_o) | (~pad_oe & res_fit & res_lvl) | (~pad_oe & ~res_fit & PIN_PULL);
endmodule

// File: bench/tb_phy_strap_option_latch.sv
// Self-checking bench of the strap option latch
`timescale 1ns/10ps
module tb_phy_strap_option_latch
  import psl_pkg::*;
;
  logic              clk = 1'b0;
  logic              rst_b = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  psl_pins_s         pad_lvl, pad_o, pad_oe;
  psl_pins_s         func = 4'hA;
  psl_pins_s         res_fit = 4'h0;
  psl_pins_s         res_lvl = 4'h0;
  logic              fib = 1'b0;
  psl_cfg_s          cfg;
  logic [3:0]        adv_cap;
  logic              done;
  int                miscompares = 0;
  int                samples_checked = 0;
  int                cyc = 0;

  // Clock and timeout
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  psl_top i_psl_top (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .strap_pad_i(pad_lvl), .strap_pad_o(pad_o),
    .strap_pad_oe(pad_oe), .strap_func_i(func), .fiber_select_i(fib), .cfg_o(cfg),
    .adv_cap_o(adv_cap), .strap_done(done));
  psl_board_model i_psl_board_model (.pad_o(pad_o), .pad_oe(pad_oe), .res_fit(res_fit),
    .res_lvl(res_lvl), .pad_lvl(pad_lvl));

  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Register port cycles
  task automatic rd(logic [ADDR_W-1:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic wr(logic [ADDR_W-1:0] a, logic [15:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // Expected configuration from strap levels and fiber select
  function automatic psl_cfg_s exp_cfg(psl_pins_s p, logic f);
    psl_cfg_s c;
    c.isolate      = p.isolate;
    c.speed_100    = f ? 1'b1 : p.speed;
    c.full_duplex  = ~p.duplex;
    c.autoneg_en   = f ? 1'b0 : p.autoneg_strap;
    c.far_fault_en = f ? p.speed : 1'b0;
    c.fiber_select = f;
    return c;
  endfunction

  // Reset with given board straps, then wait for capture and drive
  task automatic boot(psl_pins_s lvl, psl_pins_s fit, logic f);
    int n;
    @(posedge clk);
    rst_b   <= 1'b0;
    res_lvl <= lvl;
    res_fit <= fit;
    fib     <= f;
    repeat (5) @(posedge clk);
    #1 chk(16'(pad_oe), 16'h0);
    chk(16'(done), 16'h0);
    @(posedge clk);
    rst_b <= 1'b1;
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1 n++;
    end
    chk(16'(n), 16'(SETTLE_CYC + 1));
    repeat (2) @(posedge clk);
    #1;
  endtask

  // Compare configuration, advertisement and register images against the straps, pads against func
  task automatic judge(psl_pins_s p, logic f);
    psl_cfg_s    c;
    logic [15:0] d;
    logic [3:0]  cap;
    c   = exp_cfg(p, f);
    cap = c.speed_100 ? ADV_CAP_ALL : ADV_CAP_10;
    chk(16'(cfg), 16'(c));
    chk(16'(adv_cap), 16'(cap));
    rd(REG_CTRL_ADDR, d);
    chk(d, {2'h0, c.speed_100, c.autoneg_en, 1'b0, c.isolate, 1'b0, c.full_duplex, 8'h00});
    rd(REG_ADV_ADDR, d);
    chk(d, {7'h00, cap, ADV_SELECTOR});
    rd(REG_STAT_ADDR, d);
    chk(d, {13'h0000, 1'b1, c.far_fault_en, f});
    chk(16'(pad_oe), 16'hF);
    chk(16'(pad_o), 16'(func));
  endtask

  task automatic t_default();
    boot(4'h0, 4'h0, 1'b0);
    judge(PIN_PULL, 1'b0);
    $display("test default_pulls done");
  endtask

  task automatic t_table();
    for (int f = 0; f < 2; f++) begin
      for (int v = 0; v < 16; v++) begin
        boot(4'(v), 4'hF, 1'(f));
        judge(4'(v), 1'(f));
      end
    end
    $display("test strap_table done");
  endtask

  task automatic t_software();
    logic [15:0] d;
    boot(4'hF, 4'hF, 1'b1);
    wr(REG_CTRL_ADDR, 16'hFFFF);
    chk(16'(cfg), 16'h3B);
    rd(REG_CTRL_ADDR, d);
    chk(d, 16'h2500);
    wr(REG_STAT_ADDR, 16'h0000);
    rd(REG_STAT_ADDR, d);
    chk(d, 16'h0007);
    wr(REG_ADV_ADDR, 16'h0040);
    chk(16'(adv_cap), 16'h2);
    rd(REG_ADV_ADDR, d);
    chk(d, 16'h0041);
    rd(5'h10, d);
    chk(d, 16'h0000);
    // Straps and fiber select moved after capture must not matter
    @(posedge clk);
    fib     <= 1'b0;
    res_fit <= 4'h0;
    func    <= 4'h5;
    repeat (4) @(posedge clk);
    #1 chk(16'(cfg), 16'h3B);
    chk(16'(pad_o), 16'h5);
    $display("test software_access done");
  endtask

  initial begin
    t_default();
    t_table();
    t_software();
    end_of_test();
  end
endmodule
